// file: shared/clfs_pkg.sv
// comm-loss / fail supervisor: shared constants and types
// assumes a 250 MHz core clock; all times are converted to cycle counts here
package clfs_pkg;

    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned FRAME_BITS     = 16;
    localparam int unsigned NUM_DIRECT     = 4;
    localparam int unsigned NUM_CHANNELS   = 5;

    // timing figures in their own units
    localparam int unsigned WD_SHORT_MS    = 32;
    localparam int unsigned WD_LONG_MS     = 128;
    localparam int unsigned IN_DGL_US      = 200;
    localparam int unsigned RST_DGL_US     = 10;
    localparam int unsigned CLK_DGL_NS     = 2000;
    localparam int unsigned CLK_LOW_HZ     = 100;

    // derived cycle counts
    localparam int unsigned WD_SHORT_CYC   = WD_SHORT_MS * CLK_MHZ * 1000;
    localparam int unsigned WD_LONG_CYC    = WD_LONG_MS * CLK_MHZ * 1000;
    localparam int unsigned IN_DGL_CYC     = IN_DGL_US * CLK_MHZ;
    localparam int unsigned RST_DGL_CYC    = RST_DGL_US * CLK_MHZ;
    localparam int unsigned CLK_DGL_CYC    = (CLK_DGL_NS * CLK_MHZ) / 1000;
    localparam int unsigned CLK_LOW_CYC    = (CLK_MHZ * 1000000) / CLK_LOW_HZ;

    localparam int unsigned CNT_W          = 32;
    localparam int unsigned BITCNT_W       = 4;

    typedef enum logic [1:0] {
        CLFS_NORMAL = 2'b00,
        CLFS_FAIL   = 2'b01,
        CLFS_SLEEP  = 2'b10
    } clfs_mode_t;

endpackage

// file: rtl/clfs_supervisor.sv
// comm-loss / fail supervisor: spi frame checks, watchdog, input deglitchers,
// external clock monitor and external switch drive
// assumes the spi shift clock is a clock of its own, the pwm duty outputs
// and the decoded frame contents come from the surrounding logic on clk
//
// Behaviour
// - any spi fault forces fail mode
// - untoggled watchdog bit flags fault
// - no valid frame within timeout flags fault
// - frame bit count not multiple of 16
// - stuck data caught via toggle check
// - fault sets spi fault flag
// - flag held in fail, cleared leaving fail
// - fail-force above 200 us enters fail
// - direct input high 200 us takes channel
// - reset deglitched 10 us, falling edge only
// - ext clock deglitched 2 us both edges
// - clock monitor starts at reset release
// - clock fail: outputs follow channel control
// - valid clock: outputs follow duty cycle
// - clock fail latched until clear and read
// - switch drive follows channel 6 in normal
// - switch drive low in sleep or fail
// - fail mode: channels 0-3 follow filtered direct inputs, channel 4 low
// - filtered fail-force visible as status bit
`timescale 1ns/1ps
module clfs_supervisor #(
    parameter int unsigned WD_SHORT_CYC = clfs_pkg::WD_SHORT_CYC,
    parameter int unsigned WD_LONG_CYC  = clfs_pkg::WD_LONG_CYC,
    parameter int unsigned IN_DGL_CYC   = clfs_pkg::IN_DGL_CYC,
    parameter int unsigned CLK_LOW_CYC  = clfs_pkg::CLK_LOW_CYC
) (
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // spi link, shift clock domain
    input  wire logic                           spi_sclk,
    input  wire logic                           spi_cs_n,
    input  wire logic                           spi_sdi,
    // loose control and status
    input  wire logic                           watchdog_period_select,
    input  wire logic                           sleep_req,
    input  wire logic                           qstat1_read,
    input  wire logic                           ext_reset_n,
    input  wire logic                           fail_force,
    input  wire logic                           ext_clk_in,
    input  wire logic [clfs_pkg::NUM_DIRECT-1:0] direct_channel_inputs,
    input  wire logic [clfs_pkg::NUM_CHANNELS-1:0] channel_control_signal,
    input  wire logic [clfs_pkg::NUM_CHANNELS-1:0] duty_modulated,
    input  wire logic                           ch6_setting,
    output logic      [clfs_pkg::NUM_CHANNELS-1:0] channel_out,
    output logic                                ext_switch_drive,
    output logic                                spi_fault_flag,
    output logic                                filtered_fail_force,
    output logic      [clfs_pkg::NUM_DIRECT-1:0] filtered_direct_input,
    output logic                                clock_fail,
    output logic                                filtered_reset_n,
    output clfs_pkg::clfs_mode_t                mode
);

    // ------------------------------------------------------------
    // spi link domain: bit count and watchdog bit per frame
    // ------------------------------------------------------------
    // the shift clock stands still outside frames, so a frame start cannot be
    // seen from cs_n in this domain; instead frame_tog (clk domain) flips at
    // every frame end and the first shift edge of a frame finds it differing
    // from its own copy. frame_tog only moves a few clk cycles after cs_n
    // rises, while no shift edge can come, so it is steady when read here.
    // limitation: cs_n must stay high for at least four clk cycles
    logic [clfs_pkg::BITCNT_W-1:0] sbit_cnt;
    logic                          sframe_tog;
    logic                          swd_bit;
    logic                          frame_tog;

    wire                           snew          = (sframe_tog != frame_tog);
    wire [clfs_pkg::BITCNT_W-1:0]  next_sbit_cnt = snew ? 4'h1 : sbit_cnt + 4'h1;

    always_ff @(posedge spi_sclk or negedge nrst) begin
        if (!nrst) begin
            sbit_cnt   <= 4'h0;
            sframe_tog <= 1'b1;
            swd_bit    <= 1'b0;
        end else if (!spi_cs_n) begin
            sbit_cnt   <= next_sbit_cnt;
            sframe_tog <= frame_tog;
            if (snew)
                swd_bit <= spi_sdi;
        end
    end

    // cs_n end of frame, captured on clk
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic cnt_m [clfs_pkg::BITCNT_W];
    logic wd_m;
    logic wd_s;
    logic [clfs_pkg::BITCNT_W-1:0] cnt_s;

    genvar gi;
    generate
        for (gi = 0; gi < clfs_pkg::BITCNT_W; gi++) begin : g_cnt_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_m[gi] <= 1'b0;
                    cnt_s[gi] <= 1'b0;
                end else begin
                    cnt_m[gi] <= sbit_cnt[gi];
                    cnt_s[gi] <= cnt_m[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            wd_m <= 1'b0;
            wd_s <= 1'b0;
        end else begin
            cs_m <= spi_cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
            wd_m <= swd_bit;
            wd_s <= wd_m;
        end
    end

    // data bits were stable since the last shift edge, two clk edges before
    wire frame_end   = cs_s && !cs_d;
    wire len_error   = frame_end && (cnt_s != 4'h0);

    // ------------------------------------------------------------
    // watchdog toggle and timeout
    // ------------------------------------------------------------
    logic                      last_wd;
    logic                      frame_seen;
    logic [clfs_pkg::CNT_W-1:0] wd_timer;

    // first frame after reset has no previous bit to compare to
    wire toggle_error = frame_end && frame_seen && (wd_s == last_wd);
    wire good_frame   = frame_end && !len_error && !toggle_error;
    wire [clfs_pkg::CNT_W-1:0] wd_limit = watchdog_period_select ? WD_LONG_CYC[clfs_pkg::CNT_W-1:0]
                                                                : WD_SHORT_CYC[clfs_pkg::CNT_W-1:0];
    wire timeout      = (wd_timer >= wd_limit - 32'h1);
    wire comm_error   = toggle_error || len_error || timeout;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_wd    <= 1'b0;
            frame_seen <= 1'b0;
            frame_tog  <= 1'b0;
            wd_timer   <= 32'h0;
        end else begin
            if (frame_end) begin
                last_wd    <= wd_s;
                frame_seen <= 1'b1;
                frame_tog  <= ~frame_tog;
            end
            if (good_frame || timeout)
                wd_timer <= 32'h0;
            else
                wd_timer <= wd_timer + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // input deglitchers: counters after two-flop sync, cleared on agreement or at the limit
    // ------------------------------------------------------------
    localparam int unsigned NRAW = clfs_pkg::NUM_DIRECT + 2;
    logic [NRAW-1:0] raw_m;
    logic [NRAW-1:0] raw_s;
    logic [NRAW-1:0] filt;
    logic [clfs_pkg::CNT_W-1:0] dgl_cnt [NRAW];

    wire [NRAW-1:0] raw_in = {ext_clk_in, fail_force, direct_channel_inputs};

    generate
        for (gi = 0; gi < NRAW; gi++) begin : g_dgl
            localparam int unsigned LIM = (gi == NRAW - 1) ? clfs_pkg::CLK_DGL_CYC : IN_DGL_CYC;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    raw_m[gi]   <= 1'b0;
                    raw_s[gi]   <= 1'b0;
                    filt[gi]    <= 1'b0;
                    dgl_cnt[gi] <= 32'h0;
                end else begin
                    raw_m[gi] <= raw_in[gi];
                    raw_s[gi] <= raw_m[gi];
                    if (raw_s[gi] == filt[gi])
                        dgl_cnt[gi] <= 32'h0;
                    else if (dgl_cnt[gi] >= LIM[clfs_pkg::CNT_W-1:0] - 32'h1) begin
                        filt[gi]    <= raw_s[gi];
                        dgl_cnt[gi] <= 32'h0;
                    end else
                        dgl_cnt[gi] <= dgl_cnt[gi] + 32'h1;
                end
            end
        end
    endgenerate

    wire ffail = filt[NRAW-2];
    wire fclk  = filt[NRAW-1];

    // reset pin: falling edge filtered, rising edge passes at once
    logic                       rst_m;
    logic                       rst_s;
    logic                       rst_f;
    logic [clfs_pkg::CNT_W-1:0] rst_cnt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_m   <= 1'b0;
            rst_s   <= 1'b0;
            rst_f   <= 1'b0;
            rst_cnt <= 32'h0;
        end else begin
            rst_m <= ext_reset_n;
            rst_s <= rst_m;
            if (rst_s) begin
                rst_f   <= 1'b1;
                rst_cnt <= 32'h0;
            end else if (rst_f && rst_cnt >= clfs_pkg::RST_DGL_CYC[clfs_pkg::CNT_W-1:0] - 32'h1) begin
                rst_f   <= 1'b0;
                rst_cnt <= 32'h0;
            end else if (rst_f)
                rst_cnt <= rst_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // external clock monitor
    // ------------------------------------------------------------
    logic                       fclk_d;
    logic [clfs_pkg::CNT_W-1:0] period_cnt;
    logic                       clk_bad;

    wire clk_edge = fclk && !fclk_d;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fclk_d     <= 1'b0;
            period_cnt <= 32'h0;
            clk_bad    <= 1'b0;
            clock_fail <= 1'b0;
        end else begin
            fclk_d <= fclk;
            if (!rst_f || clk_edge)
                period_cnt <= 32'h0;
            else if (period_cnt < CLK_LOW_CYC[clfs_pkg::CNT_W-1:0])
                period_cnt <= period_cnt + 32'h1;
            clk_bad <= rst_f && (period_cnt >= CLK_LOW_CYC[clfs_pkg::CNT_W-1:0] - 32'h1);
            // set wins; clear only once the condition is gone and read seen
            if (clk_bad)
                clock_fail <= 1'b1;
            else if (qstat1_read)
                clock_fail <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // mode, fault flag and outputs
    // ------------------------------------------------------------
    wire to_fail = comm_error || ffail;
    clfs_pkg::clfs_mode_t next_mode;

    assign next_mode = !rst_f                 ? clfs_pkg::CLFS_NORMAL :
                       to_fail                ? clfs_pkg::CLFS_FAIL :
                       (mode == clfs_pkg::CLFS_FAIL && good_frame) ? clfs_pkg::CLFS_NORMAL :
                       (mode == clfs_pkg::CLFS_FAIL) ? clfs_pkg::CLFS_FAIL :
                       sleep_req              ? clfs_pkg::CLFS_SLEEP : clfs_pkg::CLFS_NORMAL;

    wire in_fail = (mode == clfs_pkg::CLFS_FAIL);
    wire [clfs_pkg::NUM_CHANNELS-1:0] fail_drive = {1'b0, filt[clfs_pkg::NUM_DIRECT-1:0]};
    wire [clfs_pkg::NUM_CHANNELS-1:0] next_out =
        in_fail    ? fail_drive :
        clock_fail ? channel_control_signal :
                     duty_modulated;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode                  <= clfs_pkg::CLFS_NORMAL;
            spi_fault_flag        <= 1'b0;
            channel_out           <= 5'h00;
            ext_switch_drive      <= 1'b0;
            filtered_fail_force   <= 1'b0;
            filtered_direct_input <= 4'h0;
            filtered_reset_n      <= 1'b0;
        end else begin
            mode <= next_mode;
            if (comm_error)
                spi_fault_flag <= 1'b1;
            else if (in_fail && next_mode == clfs_pkg::CLFS_NORMAL)
                spi_fault_flag <= 1'b0;
            channel_out           <= next_out;
            ext_switch_drive      <= (next_mode == clfs_pkg::CLFS_NORMAL) && ch6_setting;
            filtered_fail_force   <= ffail;
            filtered_direct_input <= filt[clfs_pkg::NUM_DIRECT-1:0];
            filtered_reset_n      <= rst_f;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_err;
        comm_error;
    endsequence
    sequence s_fail_next;
        ##1 mode == clfs_pkg::CLFS_FAIL;
    endsequence

    fault_fail_a: assert property (@(posedge clk) disable iff (!nrst)
        s_err |-> s_fail_next) else $error("comm error did not enter fail");
    toggle_chk_a: assert property (@(posedge clk) disable iff (!nrst)
        toggle_error |=> spi_fault_flag) else $error("toggle error not flagged");
    wd_timeout_a: assert property (@(posedge clk) disable iff (!nrst)
        timeout |=> wd_timer == 32'h0 && spi_fault_flag) else $error("timeout not handled");
    len_chk_a: assert property (@(posedge clk) disable iff (!nrst)
        frame_end && cnt_s != 4'h0 |=> spi_fault_flag) else $error("bad length not flagged");
    flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        in_fail && $past(in_fail) && $past(spi_fault_flag) |-> spi_fault_flag)
        else $error("fault flag dropped in fail");
    flag_clr_a: assert property (@(posedge clk) disable iff (!nrst)
        $fell(spi_fault_flag) |-> $past(in_fail) && !in_fail) else $error("flag cleared wrongly");
    sw_off_a: assert property (@(posedge clk) disable iff (!nrst)
        mode != clfs_pkg::CLFS_NORMAL |-> !ext_switch_drive) else $error("switch on outside normal");
    ff_status_a: assert property (@(posedge clk) disable iff (!nrst)
        ##1 filtered_fail_force == $past(ffail)) else $error("fail-force status stale");
    clk_latch_a: assert property (@(posedge clk) disable iff (!nrst)
        clock_fail && !qstat1_read |=> clock_fail) else $error("clock fail not latched");
    fail_out_a: assert property (@(posedge clk) disable iff (!nrst)
        in_fail |=> channel_out[3:0] == $past(filt[3:0])) else $error("fail outputs wrong");
    clk_out_a: assert property (@(posedge clk) disable iff (!nrst)
        !in_fail && clock_fail |=> channel_out == $past(channel_control_signal))
        else $error("clock fail outputs wrong");
    rst_pass_a: assert property (@(posedge clk) disable iff (!nrst)
        rst_s |=> rst_f) else $error("reset release delayed");
    sw_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        mode == clfs_pkg::CLFS_NORMAL |-> ext_switch_drive == $past(ch6_setting))
        else $error("switch drive not following channel 6");

endmodule

// file: test/clfs_host_model.sv
// host side of the spi link: frames with a watchdog bit first, then payload
// assumes the caller spaces frames; the link clock stands still between frames
`timescale 1ns/1ps
module clfs_host_model #(
    parameter int HALF_NS = 24
) (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdi
);
    logic wd_bit;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi  = 1'b0;
        wd_bit   = 1'b0;
    end

    // inv low repeats the last watchdog bit, which is the fault a test asks for
    task automatic send_frame(input int nbits, input logic inv, input logic [31:0] word);
        if (inv) wd_bit = ~wd_bit;
        #3 spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_sdi = (i == 0) ? wd_bit : word[i];
            #(HALF_NS) spi_sclk = 1'b1;
            #(HALF_NS) spi_sclk = 1'b0;
        end
        #(HALF_NS) spi_cs_n = 1'b1;
        // no pull on the data line: show the inverse rather than a stale bit
        spi_sdi = ~spi_sdi;
    endtask
endmodule

// file: test/tb.sv
// testbench for the comm-loss / fail supervisor
// assumes short deglitch and watchdog counts set by parameters below
`timescale 1ns/1ps
module tb;
    logic                                       clk = 1'b0;
    logic                                       nrst = 1'b0;
    logic                                       watchdog_period_select = 1'b0;
    logic                                       sleep_req = 1'b0;
    logic                                       qstat1_read = 1'b0;
    logic                                       ext_reset_n = 1'b1;
    logic                                       fail_force = 1'b0;
    logic                                       ext_clk_in = 1'b0;
    logic [clfs_pkg::NUM_DIRECT-1:0]            direct_channel_inputs = 4'h0;
    logic [clfs_pkg::NUM_CHANNELS-1:0]          channel_control_signal = 5'h00;
    logic [clfs_pkg::NUM_CHANNELS-1:0]          duty_modulated = 5'h00;
    logic                                       ch6_setting = 1'b0;
    logic [clfs_pkg::NUM_CHANNELS-1:0]          channel_out;
    logic [clfs_pkg::NUM_DIRECT-1:0]            filtered_direct_input;
    logic                                       ext_switch_drive;
    logic                                       spi_fault_flag;
    logic                                       filtered_fail_force;
    logic                                       clock_fail;
    logic                                       filtered_reset_n;
    clfs_pkg::clfs_mode_t                       mode;
    logic                                       spi_sclk;
    logic                                       spi_cs_n;
    logic                                       spi_sdi;
    logic [31:0]                                seed = 32'h4ee9;
    int                                         ext_half = 600;
    int                                         error_cnt = 0;
    int                                         num_checks = 0;

    always #2 clk = ~clk;
    // external clock half period in core cycles, offset so it drifts against clk
    always #(ext_half * 4 + 0.3) ext_clk_in = ~ext_clk_in;

    clfs_supervisor #(.WD_SHORT_CYC(2000), .WD_LONG_CYC(8000), .IN_DGL_CYC(20), .CLK_LOW_CYC(4000)) u_clfs_supervisor (
        .clk(clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .watchdog_period_select(watchdog_period_select), .sleep_req(sleep_req), .qstat1_read(qstat1_read),
        .ext_reset_n(ext_reset_n), .fail_force(fail_force), .ext_clk_in(ext_clk_in),
        .direct_channel_inputs(direct_channel_inputs), .channel_control_signal(channel_control_signal),
        .duty_modulated(duty_modulated), .ch6_setting(ch6_setting), .channel_out(channel_out),
        .ext_switch_drive(ext_switch_drive), .spi_fault_flag(spi_fault_flag),
        .filtered_fail_force(filtered_fail_force), .filtered_direct_input(filtered_direct_input),
        .clock_fail(clock_fail), .filtered_reset_n(filtered_reset_n), .mode(mode));

    clfs_host_model u_clfs_host_model (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [4:0] exp_chan(input logic in_fail, input logic clk_bad);
        if (in_fail) return {1'b0, direct_channel_inputs};
        return clk_bad ? channel_control_signal : duty_modulated;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input int nbits, input logic inv);
        seed = lfsr(seed);
        duty_modulated = seed[4:0];
        channel_control_signal = seed[9:5];
        u_clfs_host_model.send_frame(nbits, inv, seed);
        cyc(8);
    endtask

    task automatic chk_mode(input clfs_pkg::clfs_mode_t m, input logic flag);
        chk(8'(mode), 8'(m));
        chk(8'(spi_fault_flag), 8'(flag));
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #360000;
        error_cnt++;
        end_sim();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        cyc(4);
        for (int i = 0; i < 6; i++) begin
            frame(16 * (1 + int'(seed[3])), 1'b1);
        end
        ch6_setting = 1'b1;
        cyc(4);
        chk_mode(clfs_pkg::CLFS_NORMAL, 1'b0);
        chk(8'(ext_switch_drive), 8'h01);
        chk(8'(channel_out), 8'(exp_chan(1'b0, 1'b0)));
        u_clfs_host_model.send_frame(16, 1'b0, 32'h0);
        cyc(8);
        chk_mode(clfs_pkg::CLFS_FAIL, 1'b1);
        chk(8'(ext_switch_drive), 8'h00);
        seed = lfsr(seed);
        direct_channel_inputs = seed[3:0];
        cyc(30);
        chk(8'(filtered_direct_input), 8'(seed[3:0]));
        chk(8'(channel_out), 8'(exp_chan(1'b1, 1'b0)));
        direct_channel_inputs = ~seed[3:0];
        cyc(10);
        direct_channel_inputs = seed[3:0];
        cyc(30);
        chk(8'(filtered_direct_input), 8'(seed[3:0]));
        frame(16, 1'b0);
        chk_mode(clfs_pkg::CLFS_FAIL, 1'b1);
        frame(16, 1'b1);
        chk_mode(clfs_pkg::CLFS_NORMAL, 1'b0);
        frame(15, 1'b1);
        chk_mode(clfs_pkg::CLFS_FAIL, 1'b1);
        frame(32, 1'b1);
        frame(16, 1'b1);
        chk_mode(clfs_pkg::CLFS_NORMAL, 1'b0);
        cyc(1800);
        chk_mode(clfs_pkg::CLFS_NORMAL, 1'b0);
        cyc(400);
        chk_mode(clfs_pkg::CLFS_FAIL, 1'b1);
        watchdog_period_select = 1'b1;
        frame(16, 1'b1);
        cyc(7800);
        chk_mode(clfs_pkg::CLFS_NORMAL, 1'b0);
        cyc(400);
        chk_mode(clfs_pkg::CLFS_FAIL, 1'b1);
        frame(16, 1'b1);
        fail_force = 1'b1;
        cyc(10);
        fail_force = 1'b0;
        cyc(30);
        chk(8'(filtered_fail_force), 8'h00);
        fail_force = 1'b1;
        cyc(30);
        chk(8'(filtered_fail_force), 8'h01);
        chk(8'(mode), 8'(clfs_pkg::CLFS_FAIL));
        frame(16, 1'b1);
        chk(8'(mode), 8'(clfs_pkg::CLFS_FAIL));
        fail_force = 1'b0;
        cyc(30);
        frame(16, 1'b1);
        chk(8'(mode), 8'(clfs_pkg::CLFS_NORMAL));
        ext_half = 100;
        cyc(5000);
        chk(8'(clock_fail), 8'h01);
        chk(8'(channel_out), 8'(exp_chan(1'b0, 1'b1)));
        qstat1_read = 1'b1;
        cyc(1);
        qstat1_read = 1'b0;
        cyc(4);
        chk(8'(clock_fail), 8'h01);
        frame(16, 1'b1);
        ext_half = 600;
        cyc(2500);
        chk(8'(clock_fail), 8'h01);
        frame(16, 1'b1);
        qstat1_read = 1'b1;
        cyc(1);
        qstat1_read = 1'b0;
        cyc(4);
        chk(8'(clock_fail), 8'h00);
        chk(8'(channel_out), 8'(exp_chan(1'b0, 1'b0)));
        sleep_req = 1'b1;
        cyc(8);
        chk(8'(mode), 8'(clfs_pkg::CLFS_SLEEP));
        chk(8'(ext_switch_drive), 8'h00);
        sleep_req = 1'b0;
        ext_reset_n = 1'b0;
        cyc(1000);
        ext_reset_n = 1'b1;
        cyc(10);
        chk(8'(filtered_reset_n), 8'h01);
        ext_reset_n = 1'b0;
        cyc(2600);
        chk(8'(filtered_reset_n), 8'h00);
        ext_reset_n = 1'b1;
        cyc(6);
        chk(8'(filtered_reset_n), 8'h01);
        end_sim();
    end
endmodule
